// *** hdl/ppg_top.sv ***
// Three-channel pulse and time-mark generator with AHB-Lite register access
//
// Function
// RULE1: three independent pulse output channels
// RULE2: per-channel polarity selects asserted level
// RULE3: width 10 ms to 10 s, 10 ms steps
// RULE4: outputs gated until sync unless enabled early
// RULE5: timer mode: three on and off times
// RULE6: cyclic pulses at period aligned to midnight
// RULE7: single shot once daily at programmed time
// RULE8: per second, minute, hour pulses
// RULE9: status mode: position, sync, or both
// RULE10: idle mode holds output inactive
// RULE11: defaults: second, minute, mark emulation channels
// RULE12: active-high marks rise at each second
// RULE13: mark width 100 ms zero, 200 ms one
// RULE14: seconds 15 to 58 carry the time
// RULE15: no mark in second 59
// RULE16: marks carry local time and announcements
// RULE17: mark output active right after power-up
// RULE18: identical start/end parameters suppress daylight switching
// RULE19: lock on with four satellites and position
// RULE20: fail on until sync, or on error
// RULE21: telegram bits follow the public layout
// RULE22: 10 ms tick locked to second boundary
`timescale 1ns/1ps
`default_nettype none
`include "ppg_defs.svh"
module ppg_top #(
  parameter int TICK_CYCLES = `PPG_TICK_CYC
) (
  input  wire logic        sys_clk_in,
  input  wire logic        reset_in,
  input  wire logic        ce_in,
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output var  logic [31:0] hrdata_out,
  output var  logic        hreadyout_out,
  output var  logic        hresp_out,
  input  wire logic        second_pulse_in,
  input  wire logic        sync_in,
  input  wire logic        pos_ok_in,
  input  wire logic        sats_four_in,
  input  wire logic        severe_err_in,
  output var  logic        pulse_out_ch0_out,
  output var  logic        pulse_out_ch1_out,
  output var  logic        pulse_out_ch2_out,
  output var  logic        lock_out,
  output var  logic        fail_out
);
  import ppg_pkg::*;

  // ==========================================================================
  // Input synchronisers
  logic [4:0] meta;
  logic [4:0] sync_q;
  logic       pps_s;
  logic       sync_s;
  logic       pos_s;
  logic       sats_s;
  logic       err_s;
  logic       pps_prev;
  logic       pps_rise;

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      meta <= 5'h00;
      sync_q <= 5'h00;
    end else if (ce_in) begin
      meta <= {severe_err_in, sats_four_in, pos_ok_in, sync_in, second_pulse_in};
      sync_q <= meta;
    end
  end
  assign {err_s, sats_s, pos_s, sync_s, pps_s} = sync_q;
  assign pps_rise = pps_s && !pps_prev;

  // ==========================================================================
  // Register storage
  logic [31:0]   ctrl;
  logic [16:0]   time_reg;
  logic [31:0]   date;
  logic [31:0]   dst_start;
  logic [31:0]   dst_end;
  logic [31:0]   ch_cfg   [3];
  ppg_sod_t      ch_param [3];
  logic [101:0]  ch_times [3];
  logic          sync_seen;

  // ==========================================================================
  // AHB-Lite slave: zero wait states, always OKAY
  logic        dp_write;
  logic [7:0]  dp_addr;
  logic        ap_valid;
  logic [7:0]  ap_addr;
  logic [31:0] rd_mux;
  logic [1:0]  ap_ch;
  logic [2:0]  ap_idx;
  logic [1:0]  dp_ch;
  logic [2:0]  dp_idx;
  logic        dp_is_ch;
  logic [5:0]  sec;
  logic [5:0]  min;
  logic [4:0]  hour;

  assign ap_valid = hsel_in && htrans_in[1] && hready_in;
  assign ap_addr = haddr_in[7:0];
  assign ap_ch = 2'((ap_addr - `PPG_REG_CH_BASE) >> 5);
  assign ap_idx = ap_addr[4:2];
  assign dp_ch = 2'((dp_addr - `PPG_REG_CH_BASE) >> 5);
  assign dp_idx = dp_addr[4:2];
  // Channel space stops at its own end so higher offsets cannot alias a channel
  assign dp_is_ch = (dp_addr >= `PPG_REG_CH_BASE) && (dp_addr < `PPG_REG_CH_END) && (dp_addr[1:0] == 2'h0);

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (haddr_in[31:8] != 24'h000000 || ap_addr[1:0] != 2'h0) begin
      rd_mux = 32'h0000_0000;
    end else if (ap_addr >= `PPG_REG_CH_BASE) begin
      if (ap_addr < `PPG_REG_CH_END) begin
        case (ap_idx)
          `PPG_CH_CFG:   rd_mux = ch_cfg[ap_ch];
          `PPG_CH_PARAM: rd_mux = {15'h0000, ch_param[ap_ch]};
          default:       rd_mux = {15'h0000, ch_times[ap_ch][17*(ap_idx-3'h2) +: 17]};
        endcase
      end
    end else begin
      case (ap_addr)
        `PPG_REG_CTRL:      rd_mux = ctrl;
        `PPG_REG_STATUS:    rd_mux = {10'h000, sec, 10'h000, sats_s, err_s, fail_out, lock_out, pos_s, sync_seen};
        `PPG_REG_TIME:      rd_mux = {11'h000, hour, 2'h0, min, 2'h0, sec};
        `PPG_REG_DATE:      rd_mux = date;
        `PPG_REG_DST_START: rd_mux = dst_start;
        `PPG_REG_DST_END:   rd_mux = dst_end;
        default:            rd_mux = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      dp_write <= 1'b0;
      dp_addr <= 8'h00;
      hrdata_out <= 32'h0000_0000;
      hreadyout_out <= 1'b0;
      hresp_out <= 1'b0;
    end else if (ce_in) begin
      hreadyout_out <= 1'b1;
      dp_write <= ap_valid && hwrite_in && (haddr_in[31:8] == 24'h000000);
      if (ap_valid) begin
        dp_addr <= ap_addr;
        hrdata_out <= rd_mux;
      end
    end
  end

  // Register writes; reset values give the default channel setup
  logic time_load;
  assign time_load = dp_write && dp_addr == `PPG_REG_TIME;

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      ctrl <= 32'h0000_0000;
      date <= 32'h0000_0000;
      dst_start <= 32'h0000_0000;
      dst_end <= 32'h0000_0000;
      ch_cfg[0] <= `PPG_CFG0_RST; // RULE11
      ch_cfg[1] <= `PPG_CFG1_RST; // RULE11
      ch_cfg[2] <= `PPG_CFG2_RST; // RULE11
      for (int c = 0; c < 3; c++) begin
        ch_param[c] <= 17'h00000;
        ch_times[c] <= 102'h0;
      end
    end else if (ce_in && dp_write) begin
      if (dp_is_ch) begin
        case (dp_idx)
          `PPG_CH_CFG:   ch_cfg[dp_ch] <= hwdata_in;
          `PPG_CH_PARAM: ch_param[dp_ch] <= hwdata_in[16:0];
          default:       ch_times[dp_ch][17*(dp_idx-3'h2) +: 17] <= hwdata_in[16:0]; // RULE5
        endcase
      end else begin
        case (dp_addr)
          `PPG_REG_CTRL:      ctrl <= hwdata_in;
          `PPG_REG_DATE:      date <= hwdata_in;
          `PPG_REG_DST_START: dst_start <= hwdata_in;
          `PPG_REG_DST_END:   dst_end <= hwdata_in;
          default:            ;
        endcase
      end
    end
  end

  // ==========================================================================
  // 10 ms tick, restarted on every second edge
  logic [31:0] tick_cnt;
  logic        tick;
  logic        sec_tick;

  assign tick = (tick_cnt == 32'(TICK_CYCLES - 1));

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      tick_cnt <= 32'h0000_0000;
      pps_prev <= 1'b0;
      sec_tick <= 1'b0;
    end else if (ce_in) begin
      pps_prev <= pps_s;
      sec_tick <= pps_rise;
      if (pps_rise || tick) tick_cnt <= 32'h0000_0000; // RULE22
      else tick_cnt <= tick_cnt + 32'h0000_0001;
    end
  end

  // ==========================================================================
  // Local time of day, advanced on each second edge
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      sec <= 6'h00;
      min <= 6'h00;
      hour <= 5'h00;
    end else if (ce_in) begin
      if (time_load) begin
        sec <= hwdata_in[5:0];
        min <= hwdata_in[13:8];
        hour <= hwdata_in[20:16];
      end else if (pps_rise) begin
        sec <= (sec == `PPG_SEC_LAST) ? 6'h00 : sec + 6'h01; // RULE14
        if (sec == `PPG_SEC_LAST) begin
          min <= (min == `PPG_MIN_LAST) ? 6'h00 : min + 6'h01;
          if (min == `PPG_MIN_LAST) hour <= (hour == `PPG_HOUR_LAST) ? 5'h00 : hour + 5'h01;
        end
      end
    end
  end

  ppg_sod_t sod;
  // Widen before multiplying so the hour product cannot wrap
  assign sod = 17'(hour) * 17'h00E10 + 17'(min) * 17'h0003C + 17'(sec);

  // ==========================================================================
  // Time telegram
  function automatic logic [7:0] to_bcd(input logic [5:0] v);
    // Tens digit needs three bits for minutes 40 to 59
    to_bcd = {1'b0, 3'(v / 6'h0A), 4'(v % 6'h0A)};
  endfunction

  logic        dst_ok;
  logic [58:0] tg;
  logic [7:0]  min_bcd;
  logic [7:0]  hour_bcd;

  assign dst_ok = (dst_start != dst_end); // RULE18
  assign min_bcd = to_bcd(min);
  assign hour_bcd = to_bcd({1'b0, hour});

  always_comb begin
    tg = 59'h0;
    tg[16] = ctrl[`PPG_CTRL_DST_ANN] && dst_ok; // RULE16 RULE18
    tg[17] = ctrl[`PPG_CTRL_DST_ON] && dst_ok;  // RULE18
    tg[18] = !(ctrl[`PPG_CTRL_DST_ON] && dst_ok);
    tg[19] = ctrl[`PPG_CTRL_LEAP_ANN];           // RULE16
    tg[20] = 1'b1;
    tg[27:21] = min_bcd[6:0];                    // RULE21
    tg[28] = ^min_bcd[6:0];
    tg[34:29] = hour_bcd[5:0];
    tg[35] = ^hour_bcd[5:0];
    tg[41:36] = date[5:0];
    tg[44:42] = date[10:8];
    tg[49:45] = date[20:16];
    tg[57:50] = date[31:24];
    tg[58] = ^{date[5:0], date[10:8], date[20:16], date[31:24]};
  end

  // ==========================================================================
  // Sync gating, lock and fail
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      sync_seen <= 1'b0;
      lock_out <= 1'b0;
      fail_out <= 1'b1;
    end else if (ce_in) begin
      if (sync_s) sync_seen <= 1'b1;
      lock_out <= sats_s && pos_s;            // RULE19
      fail_out <= !sync_seen || err_s;        // RULE20
    end
  end

  // ==========================================================================
  // Channels
  logic [2:0] ch_out;
  logic       gate_en;
  assign gate_en = sync_seen || ctrl[`PPG_CTRL_EARLY_EN]; // RULE4

  for (genvar c = 0; c < 3; c++) begin : g_ch
    ppg_chan u_chan (                                      // RULE1
      .sys_clk_in  (sys_clk_in),
      .reset_in    (reset_in),
      .ce_in       (ce_in),
      .sec_tick_in (sec_tick),
      .tick_in     (tick),
      .mode_in     (ch_cfg[c][3:0]),
      .pol_in      (ch_cfg[c][`PPG_CFG_POL]),
      .width_in    (ch_cfg[c][`PPG_CFG_WIDTH_LSB +: 10]),
      .param_in    (ch_param[c]),
      .times_in    (ch_times[c]),
      .sod_in      (sod),
      .sec_in      (sec),
      .min_in      (min),
      .pos_ok_in   (pos_s),
      .sync_in     (sync_s),
      .mark_bit_in ((sec >= `PPG_MARK_FIRST) ? tg[sec] : 1'b0), // RULE14
      .enable_in   (gate_en),
      .out_out     (ch_out[c])
    );
  end
  assign pulse_out_ch0_out = ch_out[0];
  assign pulse_out_ch1_out = ch_out[1];
  assign pulse_out_ch2_out = ch_out[2];

  // ==========================================================================
  // Checks
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);

  a_lock_follow: assert property (ce_in && sats_s && pos_s |=> lock_out) // RULE19
    else $error("lock indicator not set");
  a_fail_nosync: assert property (ce_in && !sync_seen |=> fail_out) // RULE20
    else $error("fail indicator off before sync");
  a_fail_err: assert property (ce_in && err_s |=> fail_out) // RULE20
    else $error("fail indicator off during severe error");
  a_lock_drop: assert property (ce_in && !(sats_s && pos_s) |=> !lock_out) // RULE19
    else $error("lock indicator on without position");
  a_tick_align: assert property (ce_in && pps_rise |=> tick_cnt == 32'h0000_0000) // RULE22
    else $error("tick not realigned to second");
  a_sec_wrap: assert property (ce_in && pps_rise && !time_load && sec == `PPG_SEC_LAST |=> sec == 6'h00) // RULE14
    else $error("second counter did not wrap");
  a_dst_block: assert property (dst_start == dst_end |-> !tg[17] && tg[18]) // RULE18
    else $error("daylight flag set with equal parameters");
endmodule
`default_nettype wire

// *** include/ppg_defs.svh ***
// Register map, field positions, reset values and timing counts of the pulse generator
`ifndef PPG_DEFS_SVH
`define PPG_DEFS_SVH

// ==========================================================================
// Timing
`define PPG_CLK_PERIOD_NS  10
`define PPG_TICK_MS        10
`define PPG_TICK_CYC       ((`PPG_TICK_MS * 1000000) / `PPG_CLK_PERIOD_NS)
`define PPG_WIDTH_MIN      10'h001
`define PPG_WIDTH_MAX      10'h3E8
`define PPG_MARK_ZERO      10'h00A
`define PPG_MARK_ONE       10'h014
`define PPG_SEC_LAST       6'h3B
`define PPG_MIN_LAST       6'h3B
`define PPG_HOUR_LAST      5'h17
`define PPG_MARK_FIRST     6'h0F

// ==========================================================================
// Register offsets
`define PPG_REG_CTRL       8'h00
`define PPG_REG_STATUS     8'h04
`define PPG_REG_TIME       8'h08
`define PPG_REG_DATE       8'h0C
`define PPG_REG_DST_START  8'h10
`define PPG_REG_DST_END    8'h14
`define PPG_REG_CH_BASE    8'h40
`define PPG_REG_CH_STRIDE  8'h20
`define PPG_REG_CH_END     8'hA0
`define PPG_CH_CFG         3'h0
`define PPG_CH_PARAM       3'h1
`define PPG_CH_TIME0       3'h2

// ==========================================================================
// Fields
`define PPG_CTRL_EARLY_EN  0
`define PPG_CTRL_DST_ON    1
`define PPG_CTRL_DST_ANN   2
`define PPG_CTRL_LEAP_ANN  3
`define PPG_CFG_POL        4
`define PPG_CFG_WIDTH_LSB  16

// ==========================================================================
// Reset values
`define PPG_CFG0_RST       32'h0014_0014
`define PPG_CFG1_RST       32'h0014_0015
`define PPG_CFG2_RST       32'h0014_0018

`endif

// *** include/ppg_pkg.sv ***
// Types shared by the pulse generator modules
package ppg_pkg;
  typedef enum {
    PPG_IDLE,
    PPG_TIMER,
    PPG_CYCLIC,
    PPG_SINGLE,
    PPG_PER_SEC,
    PPG_PER_MIN,
    PPG_PER_HR,
    PPG_STATUS,
    PPG_TELEGRAM
  } ppg_mode_e;
  typedef logic [16:0] ppg_sod_t;
endpackage

// *** hdl/ppg_chan.sv ***
// One pulse output channel
`timescale 1ns/1ps
`default_nettype none
`include "ppg_defs.svh"
module ppg_chan (
  input  wire logic           sys_clk_in,
  input  wire logic           reset_in,
  input  wire logic           ce_in,
  input  wire logic           sec_tick_in,
  input  wire logic           tick_in,
  input  wire logic [3:0]     mode_in,
  input  wire logic           pol_in,
  input  wire logic [9:0]     width_in,
  input  wire ppg_pkg::ppg_sod_t param_in,
  input  wire logic [101:0]   times_in,
  input  wire ppg_pkg::ppg_sod_t sod_in,
  input  wire logic [5:0]     sec_in,
  input  wire logic [5:0]     min_in,
  input  wire logic           pos_ok_in,
  input  wire logic           sync_in,
  input  wire logic           mark_bit_in,
  input  wire logic           enable_in,
  output var  logic           out_out
);
  import ppg_pkg::*;

  ppg_mode_e  mode;
  logic [9:0] cnt;
  logic       timer_on;
  logic       fire;
  logic [9:0] width;
  logic       active;
  logic       on_hit;
  logic       off_hit;

  assign mode = (mode_in > 4'h8) ? PPG_IDLE : ppg_mode_e'(mode_in);
  assign width = (width_in == 10'h000) ? `PPG_WIDTH_MIN :
                 (width_in > `PPG_WIDTH_MAX) ? `PPG_WIDTH_MAX : width_in; // RULE3

  // ==========================================================================
  // Start of a pulse
  always_comb begin
    on_hit = 1'b0;
    off_hit = 1'b0;
    for (int k = 0; k < 3; k++) begin
      if (times_in[34*k +: 17] == sod_in) on_hit = 1'b1;     // RULE5
      if (times_in[34*k+17 +: 17] == sod_in) off_hit = 1'b1; // RULE5
    end
    case (mode)
      PPG_CYCLIC:   fire = (param_in != 17'h00000) && ((sod_in % param_in) == 17'h00000); // RULE6
      PPG_SINGLE:   fire = (sod_in == param_in);                          // RULE7
      PPG_PER_SEC:  fire = 1'b1;                                          // RULE8
      PPG_PER_MIN:  fire = (sec_in == 6'h00);                             // RULE8
      PPG_PER_HR:   fire = (sec_in == 6'h00) && (min_in == 6'h00);        // RULE8
      PPG_TELEGRAM: fire = (sec_in != `PPG_SEC_LAST);                     // RULE15
      default:      fire = 1'b0;
    endcase
  end

  // ==========================================================================
  // Width counter in 10 ms ticks
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      cnt <= 10'h000;
    end else if (ce_in) begin
      if (sec_tick_in && fire) begin
        if (mode == PPG_TELEGRAM) begin
          cnt <= mark_bit_in ? `PPG_MARK_ONE : `PPG_MARK_ZERO; // RULE13
        end else begin
          cnt <= width; // RULE3
        end
      end else if (tick_in && cnt != 10'h000) begin
        cnt <= cnt - 10'h001; // RULE22
      end
    end
  end

  // Timer mode holds a level between switch-on and switch-off
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      timer_on <= 1'b0;
    end else if (ce_in && sec_tick_in) begin
      if (off_hit) timer_on <= 1'b0; // RULE5
      else if (on_hit) timer_on <= 1'b1;
    end
  end

  always_comb begin
    case (mode)
      PPG_TIMER:  active = timer_on; // RULE5
      PPG_STATUS: active = (param_in[1:0] == 2'h0) ? pos_ok_in :
                           (param_in[1:0] == 2'h1) ? sync_in : (pos_ok_in && sync_in); // RULE9
      PPG_IDLE:   active = 1'b0; // RULE10
      default:    active = (cnt != 10'h000);
    endcase
  end

  // Output register; the mark output ignores polarity and sync gating
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      out_out <= 1'b0;
    end else if (ce_in) begin
      if (mode == PPG_TELEGRAM) out_out <= active; // RULE12 RULE17
      else if (!enable_in) out_out <= ~pol_in; // RULE4
      else out_out <= active ? pol_in : ~pol_in; // RULE2
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);

  sequence s_mark_start;
    ce_in && sec_tick_in && mode == PPG_TELEGRAM && sec_in != `PPG_SEC_LAST;
  endsequence
  sequence s_mark_hold;
    ce_in && mode == PPG_TELEGRAM;
  endsequence
  sequence s_sec_start;
    ce_in && sec_tick_in && mode == PPG_PER_SEC && enable_in;
  endsequence
  sequence s_sec_hold;
    ce_in && enable_in && mode == PPG_PER_SEC;
  endsequence

  a_idle_inactive: assert property (ce_in && mode == PPG_IDLE && enable_in |=> out_out == ~$past(pol_in)) // RULE10
    else $error("idle channel not inactive");
  a_mark_rise: assert property (s_mark_start ##1 s_mark_hold |=> out_out) // RULE12
    else $error("time mark did not start at second");
  a_mark_skip: assert property (ce_in && sec_tick_in && mode == PPG_TELEGRAM && // RULE15
                                sec_in == `PPG_SEC_LAST && cnt == 10'h000 |=> !out_out)
    else $error("time mark emitted in last second");
  a_gate_off: assert property (ce_in && !enable_in && mode != PPG_TELEGRAM |=> out_out == ~$past(pol_in)) // RULE4
    else $error("ungated output before sync");
  a_sec_pulse: assert property (s_sec_start ##1 s_sec_hold |=> out_out == $past(pol_in)) // RULE8
    else $error("per-second pulse missing");
endmodule
`default_nettype wire

// *** dv/ppg_rx_model.sv ***
// Receiving equipment model: counts pulses and measures their lengths
`timescale 1ns/1ps
`default_nettype none
module ppg_rx_model (
  input  wire logic             clk_in,
  input  wire logic [2:0]       line_in,
  output var  logic [2:0][31:0] rises_out,
  output var  logic [2:0][31:0] hi_w_out,
  output var  logic [2:0][31:0] lo_w_out
);
  // ==========================================================================
  // Run-length measurement per channel
  // The receiver only listens; it never drives the lines back
  logic [2:0][31:0] run;
  logic [2:0]       last;

  initial begin
    rises_out = '0;
    hi_w_out = '0;
    lo_w_out = '0;
    run = '0;
    last = '0;
  end

  always @(posedge clk_in) begin
    for (int i = 0; i < 3; i++) begin
      if (line_in[i] === last[i]) begin
        run[i] <= run[i] + 32'h1;
      end else begin
        if (last[i] === 1'b1) begin
          hi_w_out[i] <= run[i];
        end else begin
          lo_w_out[i] <= run[i];
        end
        if (line_in[i] === 1'b1) begin
          rises_out[i] <= rises_out[i] + 32'h1;
        end
        run[i] <= 32'h1;
      end
      last[i] <= line_in[i];
    end
  end
endmodule
`default_nettype wire

// *** dv/programmable_pulse_and_time_mark_outputs_test.sv ***
// Testbench of the three-channel pulse and time-mark generator
`timescale 1ns/1ps
`default_nettype none
module programmable_pulse_and_time_mark_outputs_test;
  // ==========================================================================
  // Signals
  // A short tick keeps a simulated second at a few hundred cycles
  localparam int TICKS = 10;
  localparam int SEC_CYC = 400;
  localparam int LIMIT = 20000;
  logic             clk = 1'b0;
  logic             rst = 1'b1;
  logic             hsel = 1'b0;
  logic [31:0]      haddr = 32'h0;
  logic [1:0]       htrans = 2'h0;
  logic             hwrite = 1'b0;
  logic [31:0]      hwdata = 32'h0;
  logic             sp = 1'b0;
  logic             sync = 1'b0;
  logic             pos_ok = 1'b0;
  logic             sats = 1'b0;
  logic             sev = 1'b0;
  logic [31:0]      hrdata;
  logic             hreadyout;
  logic             hresp;
  logic             p0;
  logic             p1;
  logic             p2;
  logic             lock;
  logic             fail;
  logic [2:0][31:0] rises;
  logic [2:0][31:0] hi_w;
  logic [2:0][31:0] lo_w;
  logic [31:0]      r0;
  logic [31:0]      r1;
  logic [31:0]      rd;
  int               err_total = 0;
  int               num_checks = 0;
  int               cyc = 0;

  always #5 clk = ~clk;

  ppg_top #(.TICK_CYCLES(TICKS)) u_dut (
    .sys_clk_in(clk), .reset_in(rst), .ce_in(1'b1), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
    .hready_in(hreadyout), .hrdata_out(hrdata), .hreadyout_out(hreadyout), .hresp_out(hresp),
    .second_pulse_in(sp), .sync_in(sync), .pos_ok_in(pos_ok), .sats_four_in(sats),
    .severe_err_in(sev), .pulse_out_ch0_out(p0), .pulse_out_ch1_out(p1),
    .pulse_out_ch2_out(p2), .lock_out(lock), .fail_out(fail));

  ppg_rx_model u_rx (.clk_in(clk), .line_in({p2, p1, p0}), .rises_out(rises), .hi_w_out(hi_w),
    .lo_w_out(lo_w));

  // ==========================================================================
  // Tasks
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Pulse lengths may land one cycle either way of the nominal count
  function automatic logic [31:0] near(input logic [31:0] v, input logic [31:0] e);
    return (v + 32'h1 >= e && v <= e + 32'h1) ? e : v;
  endfunction

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic step(input int n);
    repeat (n) begin
      @(posedge clk);
      sp <= 1'b1;
      repeat (5) @(posedge clk);
      sp <= 1'b0;
      repeat (SEC_CYC) @(posedge clk);
    end
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      err_total++;
      $display("timeout after %0d cycles", cyc);
      end_of_test();
    end
  end

  // ==========================================================================
  // Tests
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    chk("fail", fail, 1);
    chk("lock", lock, 0);
    bus(0, 8'h40, 0); chk("cfg0", rd, 32'h0014_0014);
    bus(0, 8'h60, 0); chk("cfg1", rd, 32'h0014_0015);
    bus(0, 8'h80, 0); chk("cfg2", rd, 32'h0014_0018);
    chk("hresp", hresp, 0);
    step(1);
    chk("ch0 before sync", rises[0], 0);
    chk("mark count", rises[2], 1);
    chk("mark zero", near(hi_w[2], 100), 100);
    $display("test reset done");
    sync <= 1'b1;
    pos_ok <= 1'b1;
    sats <= 1'b1;
    repeat (8) @(posedge clk);
    chk("fail synced", fail, 0);
    chk("lock on", lock, 1);
    sev <= 1'b1;
    repeat (8) @(posedge clk);
    chk("fail error", fail, 1);
    sev <= 1'b0;
    step(1);
    chk("second count", rises[0], 1);
    chk("second width", near(hi_w[0], 200), 200);
    $display("test status done");
    bus(1, 8'h08, 32'h0000_003A);
    r0 = rises[2];
    step(1);
    chk("no mark 59", rises[2], r0);
    step(1);
    chk("minute count", rises[1], 1);
    chk("minute width", near(hi_w[1], 200), 200);
    chk("mark sec0", near(hi_w[2], 100), 100);
    bus(1, 8'h08, 32'h0000_0113);
    step(1);
    chk("mark one", near(hi_w[2], 200), 200);
    $display("test marks done");
    bus(1, 8'h40, 32'h0001_0004);
    repeat (6) @(posedge clk);
    chk("inverted idle", p0, 1);
    r0 = rises[0];
    step(1);
    chk("short width", near(lo_w[0], 10), 10);
    chk("inverted count", rises[0], r0 + 1);
    bus(1, 8'h60, 32'h0014_0010);
    bus(1, 8'h08, 32'h0000_013B);
    repeat (6) @(posedge clk);
    r1 = rises[1];
    step(1);
    chk("idle quiet", rises[1], r1);
    bus(1, 8'h64, 32'h1);
    bus(1, 8'h60, 32'h0014_0017);
    pos_ok <= 1'b0;
    repeat (8) @(posedge clk);
    chk("status sync", p1, 1);
    bus(1, 8'h64, 32'h0);
    repeat (6) @(posedge clk);
    chk("status pos", p1, 0);
    bus(1, 8'h64, 32'h2);
    repeat (6) @(posedge clk);
    chk("status both off", p1, 0);
    pos_ok <= 1'b1;
    repeat (8) @(posedge clk);
    chk("status both on", p1, 1);
    $display("test modes done");
    bus(1, 8'h40, 32'h0001_0012);
    bus(1, 8'h44, 32'h2);
    bus(1, 8'h64, 32'hA);
    bus(1, 8'h60, 32'h0001_0013);
    bus(1, 8'h08, 32'h0000_0005);
    repeat (6) @(posedge clk);
    r0 = rises[0];
    r1 = rises[1];
    step(6);
    chk("cyclic count", rises[0], r0 + 3);
    chk("single count", rises[1], r1 + 1);
    bus(1, 8'h48, 32'hD);
    bus(1, 8'h4C, 32'hF);
    bus(1, 8'h40, 32'h0001_0011);
    step(2);
    chk("timer on", p0, 1);
    step(2);
    chk("timer off", p0, 0);
    bus(1, 8'h60, 32'h0014_0016);
    bus(1, 8'h08, 32'h0000_3B3B);
    r1 = rises[1];
    step(1);
    chk("hour count", rises[1], r1 + 1);
    bus(0, 8'h08, 0); chk("hour time", rd, 32'h0001_0000);
    $display("test schedule done");
    bus(1, 8'h00, 32'hA);
    bus(1, 8'h08, 32'h0001_0010);
    step(1);
    chk("dst held", near(hi_w[2], 100), 100);
    step(2);
    chk("leap notice", near(hi_w[2], 200), 200);
    bus(1, 8'h10, 32'h1);
    bus(1, 8'h08, 32'h0001_0010);
    step(1);
    chk("dst on", near(hi_w[2], 200), 200);
    $display("test telegram flags done");
    end_of_test();
  end
endmodule
`default_nettype wire
